// [hw/sync_serial_receiver_transmitter.v]
// Synchronous serial receiver/transmitter with AXI4-Lite register access
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sync_serial_defines.vh"

module sync_serial_receiver_transmitter (
  // Clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // AXI4-Lite write address
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  // AXI4-Lite write data
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // AXI4-Lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read address
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  // AXI4-Lite read data
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Serial link
  input  wire        tx_bit_clock,
  output reg         tx_serial_out,
  input  wire        rx_bit_clock,
  input  wire        rx_serial_in,
  // Status pins
  output reg         tx_buffer_empty,
  output reg         fill_sent,
  output reg         rx_data_available,
  output reg         rx_overrun,
  output reg         rx_parity_error,
  output reg         sync_received,
  // Three-state received data bus
  output reg  [7:0]  rx_bus_out,
  output reg         rx_bus_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Data bits per character from the length code
  function [3:0] data_len;
    input [1:0] sel;
    begin
      data_len = {2'b00, sel} + `LEN_BASE;
    end
  endfunction

  // Keep only the low len bits of a character
  function [7:0] mask_data;
    input [7:0] d;
    input [3:0] len;
    begin
      mask_data = d & ~(8'hFF << len);
    end
  endfunction

  // Parity bit for the selected sense
  function par_bit;
    input [7:0] d;
    input       even;
    begin
      par_bit = even ? (^d) : (~^d);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [3:0]  ctrl;          // Length and parity settings
  reg  [7:0]  hold_reg;      // Transmit holding register
  reg  [7:0]  fill_reg;      // Transmit fill register
  reg  [7:0]  sync_reg;      // Receive sync character
  reg  [7:0]  rx_out_reg;    // Receive output register
  reg  [2:0]  pins;          // Status/data enable and restart levels

  // Shared settings drive both directions
  wire [3:0]  len     = data_len(ctrl[`CTRL_LEN_HI:`CTRL_LEN_LO]);
  wire        par_dis = ctrl[`CTRL_PAR_DIS];
  wire        par_ev  = ctrl[`CTRL_PAR_EVEN];
  wire [3:0]  frame_n = len + {3'b000, ~par_dis};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg         aw_held;       // Write address captured
  reg         w_held;        // Write data captured
  reg  [4:0]  wr_addr;       // Captured write offset
  reg  [31:0] wr_data;       // Captured write data
  reg  [3:0]  wr_strb;       // Captured byte enables

  // A write happens once both halves are in and no answer is pending
  wire        wr_go   = aw_held & w_held & ~bvalid;
  wire        wr_lane = wr_go & wr_strb[0];
  wire        wr_ctrl = wr_lane && (wr_addr == `ADDR_CTRL);
  wire        wr_hold = wr_lane && (wr_addr == `ADDR_TX_HOLD);
  wire        wr_fill = wr_lane && (wr_addr == `ADDR_FILL);
  wire        wr_sync = wr_lane && (wr_addr == `ADDR_SYNC);
  wire        wr_pins = wr_lane && (wr_addr == `ADDR_PINS);
  wire        wr_map  = (wr_addr == `ADDR_CTRL) || (wr_addr == `ADDR_TX_HOLD)
                     || (wr_addr == `ADDR_FILL) || (wr_addr == `ADDR_SYNC)
                     || (wr_addr == `ADDR_PINS);

  // Strobe edges from software writes of the level register
  wire        swe_trail = wr_pins & ~pins[`PINS_SWE_N] & wr_data[`PINS_SWE_N];
  wire        rde_trail = wr_pins & ~pins[`PINS_RDE_N] & wr_data[`PINS_RDE_N];
  wire        rr_low    = ~pins[`PINS_RR_N];
  wire        rr_rise   = wr_pins & rr_low & wr_data[`PINS_RR_N];

  // Status word in bus layout
  wire [7:0]  status_word = {tx_buffer_empty, fill_sent, 2'b00,
                             sync_received, rx_parity_error,
                             rx_overrun, rx_data_available};

  // Write channels: each half taken on its own, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (ce) begin
      // Ready drops for the whole transaction, one beat at a time
      awready <= ~aw_held & ~bvalid & ~(awvalid & awready);
      wready  <= ~w_held & ~bvalid & ~(wvalid & wready);
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr[4:0];
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        bvalid  <= 1'b1;
        bresp   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OKAY;
        case (araddr[4:0])
          `ADDR_CTRL:    rdata <= {28'h0000000, ctrl};
          `ADDR_TX_HOLD: rdata <= {24'h000000, hold_reg};
          `ADDR_FILL:    rdata <= {24'h000000, fill_reg};
          `ADDR_SYNC:    rdata <= {24'h000000, sync_reg};
          `ADDR_RX_DATA: rdata <= {24'h000000, rx_out_reg};
          `ADDR_STATUS:  rdata <= {24'h000000, status_word};
          `ADDR_PINS:    rdata <= {29'h00000000, pins};
          default: begin
            // Unmapped offset answers an error with zero data
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Plain settings registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= `CTRL_RESET;
      fill_reg <= 8'h00;
      sync_reg <= 8'h00;
      pins     <= `PINS_RESET;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl <= wr_data[3:0];
      if (wr_fill)
        fill_reg <= wr_data[7:0];
      if (wr_sync)
        sync_reg <= wr_data[7:0];
      if (wr_pins)
        pins <= wr_data[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link synchronisers and edge finders

  reg         tck_s1, tck_s2, tck_s3;   // Transmit clock pipeline
  reg         rck_s1, rck_s2, rck_s3;   // Receive clock pipeline
  reg         rsi_s1, rsi_s2;           // Receive data pipeline

  // Same depth on clock and data keeps them aligned
  always @(posedge aclk) begin
    if (!aresetn) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      rck_s1 <= 1'b0;
      rck_s2 <= 1'b0;
      rck_s3 <= 1'b0;
      rsi_s1 <= 1'b1;
      rsi_s2 <= 1'b1;
    end else if (ce) begin
      tck_s1 <= tx_bit_clock;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      rck_s1 <= rx_bit_clock;
      rck_s2 <= rck_s1;
      rck_s3 <= rck_s2;
      rsi_s1 <= rx_serial_in;
      rsi_s2 <= rsi_s1;
    end
  end

  // Edges come from settled stages only, so flags act on clean events
  wire        tx_rise = tck_s2 & ~tck_s3;
  wire        rx_fall = ~rck_s2 & rck_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  reg  [8:0]  tx_sr;         // Bits still to leave, LSB next
  reg  [3:0]  tx_cnt;        // Bit index within current frame

  wire        tx_last  = (tx_cnt >= frame_n - 4'h1);
  wire [7:0]  tx_src   = tx_buffer_empty ? fill_reg : hold_reg;
  wire [7:0]  tx_data  = mask_data(tx_src, len);
  wire [8:0]  tx_par   = {8'h00, par_bit(tx_data, par_ev) & ~par_dis};
  wire [8:0]  tx_frame = {1'b0, tx_data} | (tx_par << len);

  // Holding, fill-sent and shift logic; a load in the same cycle as a
  // transfer lands after it, so the new character is never dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_sr           <= `ONES_FRAME;
      tx_serial_out   <= 1'b1;
      tx_cnt          <= 4'h0;
      tx_buffer_empty <= 1'b1;
      fill_sent       <= 1'b0;
      hold_reg        <= 8'h00;
    end else if (ce) begin
      if (tx_rise) begin
        if (tx_last) begin
          // Next character slot: holding if loaded, else fill
          tx_sr         <= tx_frame;
          tx_serial_out <= tx_frame[0];
          tx_cnt        <= 4'h0;
          tx_buffer_empty <= 1'b1;
          fill_sent     <= tx_buffer_empty;
        end else begin
          tx_sr         <= {1'b1, tx_sr[8:1]};
          tx_serial_out <= tx_sr[1];
          tx_cnt        <= tx_cnt + 4'h1;
          if (swe_trail)
            fill_sent   <= 1'b0;
        end
      end else if (swe_trail) begin
        fill_sent <= 1'b0;
      end
      if (wr_hold) begin
        hold_reg        <= wr_data[7:0];
        tx_buffer_empty <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  reg  [1:0]  rx_state;      // Idle, hunting or framed
  reg  [8:0]  rx_sr;         // Newest bit at the top
  reg  [3:0]  rx_cnt;        // Bits gathered in current frame
  reg         rx_skip;       // Drop the sync character's parity bit

  // Window of the newest bits after this shift
  wire [8:0]  next_rx_sr = {rsi_s2, rx_sr[8:1]};
  wire [8:0]  hunt_win   = next_rx_sr >> (`FRAME_W - len);
  wire [8:0]  frame_win  = next_rx_sr >> (`FRAME_W - frame_n);
  wire [7:0]  hunt_char  = mask_data(hunt_win[7:0], len);
  wire [7:0]  rx_char    = mask_data(frame_win[7:0], len);
  wire [8:0]  rx_pshift  = frame_win >> len;
  wire        rx_pbad    = ~par_dis
                         & (rx_pshift[0] != par_bit(rx_char, par_ev));
  wire        hunt_hit   = (hunt_char == mask_data(sync_reg, len));
  wire        frame_end  = (rx_cnt == frame_n - 4'h1);

  // Output register update pulses
  wire        do_hunt    = ce & rx_fall & (rx_state == `RX_HUNT)
                         & hunt_hit;
  wire        do_frame   = ce & rx_fall & (rx_state == `RX_SYNC)
                         & ~rx_skip & frame_end;
  wire        do_xfer    = do_hunt | do_frame;

  // Sequencing of the receive shift register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= `RX_IDLE;
      rx_sr    <= 9'h000;
      rx_cnt   <= 4'h0;
      rx_skip  <= 1'b0;
    end else if (ce) begin
      if (rr_low && !rr_rise) begin
        rx_state <= `RX_IDLE;
        rx_cnt   <= 4'h0;
        rx_skip  <= 1'b0;
      end else if (rr_rise) begin
        rx_state <= `RX_HUNT;
        rx_cnt   <= 4'h0;
      end else if (rx_fall) begin
        rx_sr <= next_rx_sr;
        case (rx_state)
          `RX_HUNT: begin
            // Compare at every bit until the sync character shows
            if (hunt_hit) begin
              rx_state <= `RX_SYNC;
              rx_skip  <= ~par_dis;
              rx_cnt   <= 4'h0;
            end
          end
          `RX_SYNC: begin
            if (rx_skip) begin
              rx_skip <= 1'b0;
              rx_cnt  <= 4'h0;
            end else if (frame_end) begin
              rx_cnt  <= 4'h0;
            end else begin
              rx_cnt  <= rx_cnt + 4'h1;
            end
          end
          default: begin
            rx_cnt <= 4'h0;
          end
        endcase
      end
    end
  end

  // Output register and receive flags; a set beats any clear, save a framed sync match, which a status-enable trailing edge clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_out_reg        <= 8'h00;
      rx_data_available <= 1'b0;
      rx_overrun        <= 1'b0;
      rx_parity_error   <= 1'b0;
      sync_received     <= 1'b0;
    end else if (ce) begin
      if (do_xfer) begin
        rx_out_reg        <= do_hunt ? hunt_char : rx_char;
        rx_data_available <= 1'b1;
        rx_overrun        <= rx_data_available | (rx_overrun
                             & ~swe_trail);
      end else begin
        if (rde_trail || rr_low)
          rx_data_available <= 1'b0;
        if (swe_trail || rr_low)
          rx_overrun <= 1'b0;
      end
      if (do_hunt)
        sync_received <= 1'b1;
      else if (do_frame)
        sync_received <= (rx_char == mask_data(sync_reg, len))
                         & ~swe_trail;
      else if (swe_trail || rr_low)
        sync_received <= 1'b0;
      if (do_frame)
        rx_parity_error <= rx_pbad;
      else if (swe_trail || rr_low)
        rx_parity_error <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output bus multiplexer

  // Only one enable low selects; both or neither float the bus
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_bus_out <= 8'h00;
      rx_bus_oe  <= 1'b0;
    end else if (ce) begin
      if (!pins[`PINS_SWE_N] && pins[`PINS_RDE_N]) begin
        rx_bus_out <= status_word;
        rx_bus_oe  <= 1'b1;
      end else if (pins[`PINS_SWE_N] && !pins[`PINS_RDE_N]) begin
        rx_bus_out <= rx_out_reg;
        rx_bus_oe  <= 1'b1;
      end else begin
        rx_bus_out <= 8'h00;
        rx_bus_oe  <= 1'b0;
      end
    end
  end

endmodule

// [hw/sync_serial_defines.vh]
// Constants for the synchronous serial receiver/transmitter block
// Contract
// - NRZ, receiver shifts LSB first on falling edge
// - transmitter starts new bit on rising edge
// - right-justified characters, LSB first, upper lines ignored
// - shared length and parity settings
// - parity appended after data bits
// - holding load clears buffer-empty flag
// - transfer to shift register sets buffer-empty
// - fill character sent when nothing loaded
// - fill-sent flag set and clear conditions
// - reset sends all ones, empty set, fill-sent cleared
// - reset clears receive flags, inhibits sync hunting
// - sync strobe loads sync register
// - hunt bitwise, then frame one character per time
// - sync-received flag set and clear conditions
// - output register load sets data-available; clears
// - status word and data multiplexed on bus
// - bus three-state when nothing selected
// - length code 00..11 gives five..eight bits
// - parity disable, even when high, odd when low
// - overrun flag on overwrite, clear conditions
// - restart low resets receiver, rising edge hunts
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH

// Register byte offsets (low five address bits)
`define ADDR_CTRL      5'h00
`define ADDR_TX_HOLD   5'h04
`define ADDR_FILL      5'h08
`define ADDR_SYNC      5'h0C
`define ADDR_RX_DATA   5'h10
`define ADDR_STATUS    5'h14
`define ADDR_PINS      5'h18

// Control register fields
`define CTRL_LEN_LO    0
`define CTRL_LEN_HI    1
`define CTRL_PAR_DIS   2
`define CTRL_PAR_EVEN  3
`define CTRL_RESET     4'h0

// Strobe level register fields
`define PINS_SWE_N     0
`define PINS_RDE_N     1
`define PINS_RR_N      2
`define PINS_RESET     3'h7

// Status word bit positions on the output bus
`define ST_RDA         0
`define ST_ROR         1
`define ST_RPE         2
`define ST_SCR         3
`define ST_FCT         6
`define ST_TX_BUFFER_EMPTY        7

// Character framing
`define LEN_BASE       4'h5
`define FRAME_W        4'h9
`define ONES_FRAME     9'h1FF

// Receiver states
`define RX_IDLE        2'h0
`define RX_HUNT        2'h1
`define RX_SYNC        2'h2

// Bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [tb/sync_serial_properties.sv]
// Port checker for the synchronous serial block, bound to its top module
`timescale 1ns/1ps
module sync_serial_checker (
  // Clock and reset
  input logic       aclk,
  input logic       aresetn,
  // Write answer
  input logic       bvalid,
  // Link
  input logic       tx_bit_clock,
  input logic       tx_serial_out,
  input logic       rx_bit_clock,
  // Status and bus
  input logic       tx_buffer_empty,
  input logic       fill_sent,
  input logic       rx_data_available,
  input logic       rx_overrun,
  input logic       rx_parity_error,
  input logic       sync_received,
  input logic [7:0] rx_bus_out,
  input logic       rx_bus_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Synchronised clock edges seen a few cycles back, loose on latency
  sequence s_tx_rise;
    $past(tx_bit_clock, 2) && !$past(tx_bit_clock, 7);
  endsequence
  sequence s_rx_fall;
    !$past(rx_bit_clock, 2) && $past(rx_bit_clock, 7);
  endsequence
  property p_reset_state;
    $rose(aresetn) |-> tx_serial_out && tx_buffer_empty && !fill_sent
      && !rx_data_available && !rx_parity_error && !sync_received;
  endproperty
  property p_tx_edge;
    $changed(tx_serial_out) |-> s_tx_rise;
  endproperty
  property p_empty_set;
    $rose(tx_buffer_empty) |-> s_tx_rise;
  endproperty
  property p_empty_clear;
    $fell(tx_buffer_empty) |-> $rose(bvalid);
  endproperty
  property p_fill_set;
    $rose(fill_sent) |-> tx_buffer_empty ##0 s_tx_rise;
  endproperty
  property p_fill_clear;
    $fell(fill_sent) |-> $rose(tx_buffer_empty) || bvalid || $past(bvalid);
  endproperty
  property p_avail_set;
    $rose(rx_data_available) |-> s_rx_fall;
  endproperty
  property p_overrun_set;
    $rose(rx_overrun) |-> $past(rx_data_available);
  endproperty
  property p_sync_set;
    $rose(sync_received) |-> rx_data_available;
  endproperty
  property p_bus_off;
    !rx_bus_oe |-> rx_bus_out == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("flags wrong after reset");
  a_tx_edge: assert property (p_tx_edge)
    else $error("serial out changed off a clock rise");
  a_empty_set: assert property (p_empty_set)
    else $error("empty flag set off a clock rise");
  a_empty_clear: assert property (p_empty_clear)
    else $error("empty flag cleared without a write");
  a_fill_set: assert property (p_fill_set)
    else $error("fill flag set wrongly");
  a_fill_clear: assert property (p_fill_clear)
    else $error("fill flag cleared wrongly");
  a_avail_set: assert property (p_avail_set)
    else $error("data flag set off a clock fall");
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun without pending data");
  a_sync_set: assert property (p_sync_set)
    else $error("sync flag without a character");
  a_bus_off: assert property (p_bus_off)
    else $error("bus data while not driven");
endmodule
bind sync_serial_receiver_transmitter sync_serial_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
  .tx_bit_clock(tx_bit_clock), .tx_serial_out(tx_serial_out),
  .rx_bit_clock(rx_bit_clock), .tx_buffer_empty(tx_buffer_empty),
  .fill_sent(fill_sent), .rx_data_available(rx_data_available),
  .rx_overrun(rx_overrun), .rx_parity_error(rx_parity_error),
  .sync_received(sync_received), .rx_bus_out(rx_bus_out),
  .rx_bus_oe(rx_bus_oe));

// [tb/serial_link_model.sv]
// Far end of the serial link: bit clocks, receive data, transmit capture
`timescale 1ns/1ps
module serial_link_model (
  // Bench control
  input  logic        go,
  input  int          n_bits,
  input  logic [63:0] rx_bits,
  output logic        busy = 1'b0,
  output logic [63:0] tx_cap = 64'h0,
  // Link pins
  input  logic        tx_serial_out,
  output logic        tx_bit_clock = 1'b0,
  output logic        rx_bit_clock = 1'b0,
  output logic        rx_serial_in = 1'b1
);
  // One burst of bit periods; clocks stand low between bursts
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 0; i < n_bits; i++) begin
      // New bit at the rise so it is steady at the sampling fall
      rx_serial_in = rx_bits[i];
      tx_bit_clock = 1'b1;
      rx_bit_clock = 1'b1;
      #62.5;
      tx_bit_clock = 1'b0;
      rx_bit_clock = 1'b0;
      // Bit launched at this rise has settled by now
      tx_cap[i] = tx_serial_out;
      #62.5;
    end
    // Released line must not keep showing the last bit
    rx_serial_in = ~rx_serial_in;
    busy = 1'b0;
  end
endmodule

// [tb/sync_serial_receiver_transmitter_tb.sv]
// Self-checking bench for the synchronous serial block
`timescale 1ns/1ps
module sync_serial_receiver_transmitter_tb;
  // Bus master and reset
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid, tx_serial_out;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tx_buffer_empty, fill_sent, rx_data_available, rx_overrun;
  logic        rx_parity_error, sync_received, rx_bus_oe;
  logic [7:0]  rx_bus_out;
  // Link and partner control
  logic        tx_bit_clock, rx_bit_clock, rx_serial_in, busy;
  logic        go = 1'b0;
  int          n_bits = 0;
  logic [63:0] rx_bits = 64'h0, tx_cap;
  // Expected answers, oldest first
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [31:0] seed = 32'h0000000C;
  int          err_total = 0, checks = 0;

  always #5 aclk = ~aclk;

  sync_serial_receiver_transmitter u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_bit_clock(tx_bit_clock), .tx_serial_out(tx_serial_out),
    .rx_bit_clock(rx_bit_clock), .rx_serial_in(rx_serial_in),
    .tx_buffer_empty(tx_buffer_empty), .fill_sent(fill_sent),
    .rx_data_available(rx_data_available), .rx_overrun(rx_overrun),
    .rx_parity_error(rx_parity_error), .sync_received(sync_received),
    .rx_bus_out(rx_bus_out), .rx_bus_oe(rx_bus_oe));

  serial_link_model u_link (
    .go(go), .n_bits(n_bits), .rx_bits(rx_bits), .busy(busy),
    .tx_cap(tx_cap), .tx_serial_out(tx_serial_out),
    .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
    .rx_serial_in(rx_serial_in));

  ////////////////////////////////////////////////////////////////////////
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Frame LSB first for control code c, parity bit above the data
  function automatic logic [8:0] frm(input logic [7:0] d,
                                     input logic [3:0] c);
    logic [8:0] f;
    int         n;
    n = 5 + c[1:0];
    f = {1'b0, d} & ((9'h001 << n) - 9'h001);
    if (!c[2]) f[n] = c[3] ? ^f : ~^f;
    return f;
  endfunction

  task automatic chk(input string nm, input logic [33:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Bus pins a little after a strobe level change
  task automatic bus(input logic [8:0] e);
    repeat (3) @(posedge aclk);
    chk("bus", {25'h0, rx_bus_oe, rx_bus_out}, {25'h0, e});
  endtask

  task automatic run();
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
  endtask

  // Answer watcher: every response against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready)
      chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      chk("rdata", {rresp, rdata}, rq.pop_front());
  end

  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0]  sy, d2;
    logic [3:0]  c;
    logic [8:0]  hf, ff, f1, f2;
    int          fl, ok, found;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h14, 34'h080);
    rd(32'h00, 34'h000);
    rd(32'h18, 34'h007);
    rd(32'h1C, {2'b10, 32'h0});
    wr(32'h1C, 32'h5, 2'b10);
    // Every length code with odd, none, even, none parity
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      c = {i[1:0], i[1:0]};
      wr(32'h00, {28'h0, c}, 2'b00);
      wr(32'h08, {24'h0, r[15:8]}, 2'b00);
      wr(32'h04, {24'h0, r[7:0]}, 2'b00);
      rd(32'h14, 34'h000);
      n_bits = 48;
      run();
      hf = frm(r[7:0], c);
      ff = frm(r[15:8], c);
      fl = 5 + c[1:0] + !c[2];
      found = 0;
      for (int k = 0; k < 13; k++) begin
        ok = 1;
        for (int j = 0; j < 3 * fl; j++)
          if (tx_cap[k + j] !== (j < fl ? hf[j] : ff[(j - fl) % fl])) ok = 0;
        if (ok != 0) found = 1;
      end
      chk("tx frames", 34'(found), 34'h1);
      rd(32'h14, 34'h0C0);
      wr(32'h18, 32'h6, 2'b00);
      wr(32'h18, 32'h7, 2'b00);
      rd(32'h14, 34'h080);
    end
    // Receive: sync, skipped parity slot, good frame, bad frame
    r = rnd();
    c = 4'h9;
    sy = {2'b00, r[5:1], 1'b1};
    d2 = sy ^ 8'h02;
    wr(32'h00, 32'h9, 2'b00);
    wr(32'h0C, {24'h0, sy}, 2'b00);
    wr(32'h18, 32'h3, 2'b00);
    wr(32'h18, 32'h7, 2'b00);
    f1 = frm(r[15:8], c);
    f2 = frm(d2, c) ^ 9'h040;
    rx_bits <= {43'h0, f2[6:0], f1[6:0], 1'b0, sy[5:0]};
    n_bits = 21;
    run();
    rd(32'h14, 34'h0C7);
    rd(32'h10, {28'h0, d2[5:0]});
    wr(32'h18, 32'h6, 2'b00);
    bus(9'h1C7);
    wr(32'h18, 32'h7, 2'b00);
    bus(9'h000);
    wr(32'h18, 32'h5, 2'b00);
    bus({3'b100, d2[5:0]});
    wr(32'h18, 32'h7, 2'b00);
    rd(32'h14, 34'h080);
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule
